/* File: hdl/tcu_map.svh */
// constants for the timer capture and compare units
`ifndef TCU_MAP_SVH
`define TCU_MAP_SVH

`define TCU_MODE_NORMAL 4'h0
`define TCU_MODE_CTC_A 4'h4
`define TCU_MODE_CTC_CAP 4'hc
`define TCU_MODE_FAST_A 4'hf
`define TCU_FILTER_SAMPLES 4
`define TCU_DATA_RESET 16'h0000

`endif

/* File: hdl/tcu_pkg.sv */
// types shared by the timer capture and compare units
`default_nettype none
package tcu_pkg;
	typedef logic [15:0] tcu_word_t;
	typedef logic [7:0] tcu_byte_t;
	typedef logic [3:0] tcu_mode_t;
	typedef enum {
		tcu_sel_none,
		tcu_sel_low,
		tcu_sel_high
	} tcu_byte_sel_t;
endpackage : tcu_pkg
`default_nettype wire

/* File: hdl/tcu_cmp_if.sv */
// carrier between the top and each compare unit
`default_nettype none
interface tcu_cmp_if;
	import tcu_pkg::*;
	tcu_word_t count;
	tcu_byte_t latch;
	tcu_byte_t wdata;
	logic wr_low;
	logic buffered;
	logic load_now;
	logic timer_tick;
	logic block;
	tcu_word_t value;
	tcu_word_t current;
	logic match;
	modport top (output count, latch, wdata, wr_low, buffered, load_now,
		timer_tick, block, input value, current, match);
	modport unit (input count, latch, wdata, wr_low, buffered, load_now,
		timer_tick, block, output value, current, match);
endinterface : tcu_cmp_if
`default_nettype wire

/* File: hdl/tcu_compare.sv */
// one compare unit: buffer, compare register and match pulse
`include "tcu_map.svh"
`default_nettype none
module tcu_compare (
	input wire logic core_clk,
	input wire logic srst,
	tcu_cmp_if.unit cmp
);
	import tcu_pkg::*;

	tcu_word_t buffer;
	tcu_word_t active;
	logic hit;
	logic pending;

	assign hit = (cmp.count == active) && !cmp.block;

	// ----------------------------------------
	// value registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			buffer <= `TCU_DATA_RESET;
			active <= `TCU_DATA_RESET;
		end else begin
			if (cmp.wr_low && cmp.buffered)
				buffer <= {cmp.latch, cmp.wdata};
			if (cmp.wr_low && !cmp.buffered)
				active <= {cmp.latch, cmp.wdata};
			else if (cmp.buffered && cmp.load_now)
				active <= buffer;
		end
	end

	// match is taken on a timer tick, one tick after equality was seen
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pending <= 1'b0;
		end else if (cmp.timer_tick) begin
			pending <= hit;
		end
	end

	// a match already pending is dropped too on the blocked tick
	assign cmp.match = pending && cmp.timer_tick && !cmp.block;
	assign cmp.value = cmp.buffered ? buffer : active;
	assign cmp.current = active;
endmodule : tcu_compare
`default_nettype wire

/* File: hdl/tcu_capture_front.sv */
// shared synchroniser, optional four-sample filter and edge detector
`include "tcu_map.svh"
`default_nettype none
module tcu_capture_front #(
	parameter int SAMPLES = `TCU_FILTER_SAMPLES
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic raw_pin,
	input wire logic raw_cmp,
	input wire logic use_cmp,
	input wire logic filter_on,
	input wire logic enable,
	input wire logic rising,
	output logic edge_pulse
);
	import tcu_pkg::*;

	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic [SAMPLES-2:0] hist;
	logic filtered;
	logic prev;
	logic level;

	// select after the flops so a source switch never meets a raw level
	wire picked = use_cmp ? sync_b[1] : sync_b[0];
	// current sample plus the last three: filter adds exactly four clocks
	wire all_high = &{hist, picked};
	wire all_low = ~|{hist, picked};
	assign level = filter_on ? filtered : picked;
	wire seen_rise = level && !prev;
	wire seen_fall = !level && prev;

	// ----------------------------------------
	// synchroniser and filter
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
		end else begin
			sync_a <= {raw_cmp, raw_pin};
			sync_b <= sync_a;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			hist <= '0;
			filtered <= 1'b0;
		end else begin
			hist <= {hist[SAMPLES-3:0], picked};
			if (all_high)
				filtered <= 1'b1;
			else if (all_low)
				filtered <= 1'b0;
		end
	end

	// prev tracks even while disabled, so re-enabling makes no false edge
	always_ff @(posedge core_clk) begin
		if (srst) begin
			prev <= 1'b0;
		end else begin
			prev <= level;
		end
	end

	// unregistered so the capture lands three clocks after the pin
	assign edge_pulse = enable && (rising ? seen_rise : seen_fall);
endmodule : tcu_capture_front
`default_nettype wire

/* File: hdl/tcu_units.sv */
// top of the timer capture and compare units
`include "tcu_map.svh"
`default_nettype none
module tcu_units (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic capture_pin,
	input wire logic comparator_output,
	input wire logic comparator_capture_select,
	input wire logic capture_filter_enable,
	input wire logic capture_edge_select,
	input wire tcu_pkg::tcu_mode_t waveform_mode,
	input wire tcu_pkg::tcu_word_t timer_count,
	input wire logic timer_tick,
	input wire logic timer_count_write,
	input wire logic at_top,
	input wire logic at_bottom,
	input wire logic capture_irq_enable,
	input wire logic [1:0] compare_irq_enable,
	input wire logic capture_flag_clear,
	input wire logic [1:0] compare_flag_clear,
	input wire logic capture_irq_ack,
	input wire logic [1:0] compare_irq_ack,
	input wire logic [1:0] force_compare_strobe,
	input wire tcu_pkg::tcu_byte_t cpu_wdata,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [2:0] cpu_reg,
	output tcu_pkg::tcu_byte_t cpu_rdata,
	output tcu_pkg::tcu_word_t capture_value,
	output logic capture_flag,
	output logic [1:0] compare_flag,
	output logic capture_irq,
	output logic [1:0] compare_irq,
	output logic [1:0] compare_event,
	output tcu_pkg::tcu_word_t top_value,
	output logic top_from_capture
);
	import tcu_pkg::*;

	// cpu_reg: 0 cap low, 1 cap high, 2/3 cmp a low/high, 4/5 cmp b low/high
	tcu_byte_t latch;
	logic cap_edge;
	tcu_cmp_if cmp_bus[2] ();

	wire cap_top_mode = (waveform_mode == `TCU_MODE_CTC_CAP);
	wire pwm_mode = (waveform_mode != `TCU_MODE_NORMAL) &&
		(waveform_mode != `TCU_MODE_CTC_A) && !cap_top_mode;
	wire wr_cap_low = cpu_wr && cpu_reg == 3'h0 && cap_top_mode;
	wire rd_cap_low = cpu_rd && cpu_reg == 3'h0;
	wire wr_any_high = cpu_wr && cpu_reg[0];
	wire load_now = timer_tick && (at_top || at_bottom);

	// ----------------------------------------
	// capture path
	// ----------------------------------------
	tcu_capture_front front (
		.core_clk(core_clk),
		.srst(srst),
		.raw_pin(capture_pin),
		.raw_cmp(comparator_output),
		.use_cmp(comparator_capture_select),
		.filter_on(capture_filter_enable),
		.enable(!cap_top_mode),
		.rising(capture_edge_select),
		.edge_pulse(cap_edge)
	);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			capture_value <= `TCU_DATA_RESET;
			capture_flag <= 1'b0;
		end else begin
			if (wr_cap_low)
				capture_value <= {latch, cpu_wdata};
			else if (cap_edge)
				capture_value <= timer_count;
			if (cap_edge)
				capture_flag <= 1'b1;
			else if (capture_flag_clear || capture_irq_ack)
				capture_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// shared high-byte latch and read port
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			latch <= 8'h00;
		end else if (wr_any_high) begin
			latch <= cpu_wdata;
		end else if (rd_cap_low) begin
			latch <= capture_value[15:8];
		end
	end

	wire tcu_word_t val_a = cmp_bus[0].value;
	wire tcu_word_t val_b = cmp_bus[1].value;
	wire tcu_word_t top_a = cmp_bus[0].current;
	tcu_byte_t next_rdata;
	always_comb begin
		case (cpu_reg)
			3'h0: next_rdata = capture_value[7:0];
			3'h1: next_rdata = latch;
			3'h2: next_rdata = val_a[7:0];
			3'h3: next_rdata = val_a[15:8];
			3'h4: next_rdata = val_b[7:0];
			3'h5: next_rdata = val_b[15:8];
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			cpu_rdata <= 8'h00;
		else if (cpu_rd)
			cpu_rdata <= next_rdata;
	end

	// ----------------------------------------
	// compare units
	// ----------------------------------------
	// a tick after a count write is blocked only if no tick came between
	logic block_next;
	always_ff @(posedge core_clk) begin
		if (srst)
			block_next <= 1'b0;
		else if (timer_count_write)
			block_next <= 1'b1;
		else if (timer_tick)
			block_next <= 1'b0;
	end

	logic [1:0] cmp_match;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_cmp
			wire [2:0] low_addr = 3'(2 + 2 * g);
			assign cmp_bus[g].count = timer_count;
			assign cmp_bus[g].latch = latch;
			assign cmp_bus[g].wdata = cpu_wdata;
			assign cmp_bus[g].wr_low = cpu_wr && cpu_reg == low_addr;
			assign cmp_bus[g].buffered = pwm_mode;
			assign cmp_bus[g].load_now = load_now;
			assign cmp_bus[g].timer_tick = timer_tick;
			assign cmp_bus[g].block = block_next || timer_count_write;
			assign cmp_match[g] = cmp_bus[g].match;

			tcu_compare unit (
				.core_clk(core_clk),
				.srst(srst),
				.cmp(cmp_bus[g])
			);

			always_ff @(posedge core_clk) begin
				if (srst) begin
					compare_flag[g] <= 1'b0;
					compare_event[g] <= 1'b0;
					compare_irq[g] <= 1'b0;
				end else begin
					if (cmp_match[g])
						compare_flag[g] <= 1'b1;
					else if (compare_flag_clear[g] || compare_irq_ack[g])
						compare_flag[g] <= 1'b0;
					compare_event[g] <= cmp_match[g] ||
						(force_compare_strobe[g] && !pwm_mode);
					compare_irq[g] <= compare_irq_enable[g] &&
						(cmp_match[g] || (compare_flag[g] &&
						!(compare_flag_clear[g] || compare_irq_ack[g])));
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// top value and capture interrupt
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			capture_irq <= 1'b0;
			top_value <= `TCU_DATA_RESET;
			top_from_capture <= 1'b0;
		end else begin
			capture_irq <= capture_irq_enable && (cap_edge || (capture_flag
				&& !(capture_flag_clear || capture_irq_ack)));
			top_from_capture <= cap_top_mode;
			top_value <= cap_top_mode ? capture_value : top_a;
		end
	end
endmodule : tcu_units
`default_nettype wire

/* File: test/tcu_units_asserts.sv */
// port checker for the timer capture and compare units
`default_nettype none
module tcu_units_asserts (
	input wire logic core_clk,
	input wire logic srst,
	input wire tcu_pkg::tcu_mode_t waveform_mode,
	input wire logic timer_tick,
	input wire logic timer_count_write,
	input wire logic capture_irq_enable,
	input wire logic [1:0] compare_irq_enable,
	input wire logic [1:0] compare_irq,
	input wire logic [1:0] force_compare_strobe,
	input wire tcu_pkg::tcu_word_t capture_value,
	input wire logic capture_flag,
	input wire logic [1:0] compare_flag,
	input wire logic capture_irq,
	input wire logic [1:0] compare_event,
	input wire tcu_pkg::tcu_word_t top_value,
	input wire logic top_from_capture
);
	import tcu_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// ----
	// derived mode decodes
	// ----
	logic cap_mode;
	logic no_pwm;
	assign cap_mode = waveform_mode == 4'hc;
	assign no_pwm = cap_mode || waveform_mode == 4'h0 || waveform_mode == 4'h4;
	a_cap_flag_sync: assert property ($changed(capture_value)
		&& !$past(cap_mode) |-> capture_flag) else $error("value without flag");
	a_cap_irq_follow: assert property (!$past(srst) |-> capture_irq ==
		($past(capture_irq_enable) && capture_flag)) else $error("irq mismatch");
	a_cmp_irq_follow: assert property (!$past(srst) |-> compare_irq ==
		($past(compare_irq_enable) & compare_flag)) else $error("cmp irq bad");
	a_no_cap_top: assert property (cap_mode [*8] |->
		!$rose(capture_flag)) else $error("capture in top mode");
	a_cmp_on_tick: assert property ($rose(compare_flag[0]) |->
		$past(timer_tick)) else $error("flag without tick");
	a_force_event: assert property (force_compare_strobe[0] && no_pwm
		&& !timer_tick |=> compare_event[0] && !$rose(compare_flag[0]))
		else $error("force misbehaved");
	a_force_pwm: assert property (force_compare_strobe[1] && !no_pwm
		&& !timer_tick |=> !compare_event[1]) else $error("force in pwm");
	a_write_block: assert property ((timer_count_write ||
		$past(timer_count_write)) && timer_tick
		&& force_compare_strobe == 2'h0 |=> compare_event == 2'h0)
		else $error("match not blocked");
	a_top_source: assert property (!$past(srst) |-> top_from_capture ==
		$past(cap_mode)) else $error("top source wrong");
	a_top_capture: assert property (!$past(srst) && $past(cap_mode) |->
		top_value == $past(capture_value)) else $error("top value wrong");
	cover property ($rose(capture_flag));
	cover property ($rose(compare_flag[0]));
	cover property ($rose(top_from_capture));
endmodule : tcu_units_asserts
bind tcu_units tcu_units_asserts chk (.*);
`default_nettype wire

/* File: test/tcu_event_src.sv */
// far-side source of the capture pin and comparator output
`default_nettype none
module tcu_event_src (
	input wire logic core_clk,
	output logic capture_pin,
	output logic comparator_output
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		capture_pin = 1'h0;
		comparator_output = 1'h0;
	end
	// levels move just after an edge and then hold, never glitch mid-cycle
	task automatic drive(input logic pin, input logic cmp);
		@(posedge core_clk);
		capture_pin <= pin;
		comparator_output <= cmp;
	endtask : drive
endmodule : tcu_event_src
`default_nettype wire

/* File: test/tb_timer_capture_compare_units.sv */
// self-checking bench for the timer capture and compare units
`default_nettype none
module tb_timer_capture_compare_units;
	import tcu_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'h0;
	logic srst = 1'h1;
	logic capture_pin, comparator_output, capture_flag, capture_irq;
	logic comparator_capture_select = 1'h0;
	logic capture_filter_enable = 1'h0;
	logic capture_edge_select = 1'h1;
	logic timer_tick = 1'h0;
	logic timer_count_write = 1'h0;
	logic at_top = 1'h0;
	logic at_bottom = 1'h0;
	logic capture_irq_enable = 1'h1;
	logic capture_flag_clear = 1'h0;
	logic capture_irq_ack = 1'h0;
	logic cpu_wr = 1'h0;
	logic cpu_rd = 1'h0;
	logic top_from_capture;
	logic [1:0] compare_irq_enable = 2'h3;
	logic [1:0] compare_flag_clear = 2'h0;
	logic [1:0] compare_irq_ack = 2'h0;
	logic [1:0] force_compare_strobe = 2'h0;
	logic [1:0] compare_flag, compare_irq, compare_event;
	logic [2:0] cpu_reg = 3'h0;
	tcu_mode_t waveform_mode = 4'h0;
	tcu_word_t timer_count = 16'h0000;
	tcu_word_t capture_value, top_value;
	tcu_byte_t cpu_wdata = 8'h00;
	tcu_byte_t cpu_rdata;
	int failures = 0;
	int tests_run = 0;
	int n, m;
	tcu_units dut (.*);
	tcu_event_src src (.core_clk, .capture_pin, .comparator_output);
	always #2.5 core_clk = ~core_clk;
	// ----
	// access tasks
	// ----
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic setup(input tcu_mode_t md, input tcu_word_t c);
		@(posedge core_clk);
		waveform_mode <= md;
		timer_count <= c;
	endtask : setup
	task automatic wr(input logic [2:0] r, input tcu_byte_t d);
		@(posedge core_clk);
		cpu_reg <= r;
		cpu_wdata <= d;
		cpu_wr <= 1'h1;
		@(posedge core_clk);
		cpu_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [2:0] r, input tcu_byte_t e, input string nm);
		@(posedge core_clk);
		cpu_reg <= r;
		cpu_rd <= 1'h1;
		@(posedge core_clk);
		cpu_rd <= 1'h0;
		#1;
		chk(nm, cpu_rdata, e);
	endtask : rd
	task automatic tick(input int k);
		repeat (k) begin
			@(posedge core_clk);
			timer_tick <= 1'h1;
			@(posedge core_clk);
			timer_tick <= 1'h0;
		end
	endtask : tick
	task automatic clr;
		@(posedge core_clk);
		capture_flag_clear <= 1'h1;
		@(posedge core_clk);
		capture_flag_clear <= 1'h0;
		cyc(1);
	endtask : clr
	// bounded so a dead capture path cannot hang the run
	task automatic lat(output int k);
		k = 0;
		while (capture_flag !== 1'h1 && k < 20) begin
			cyc(1);
			k++;
		end
	endtask : lat
	task automatic results;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	initial begin
		#100000;
		failures++;
		results();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		srst <= 1'h0;
		wr(3'h3, 8'h12);
		wr(3'h2, 8'h34);
		rd(3'h3, 8'h12, "cmpa_high");
		rd(3'h2, 8'h34, "cmpa_low");
		chk("top_cmp", top_value, 16'h1234);
		setup(4'h0, 16'h1234);
		tick(2);
		cyc(2);
		chk("cmp_flag", compare_flag, 2'h1);
		chk("cmp_irq", compare_irq, 2'h1);
		@(posedge core_clk);
		compare_flag_clear <= 2'h1;
		timer_count_write <= 1'h1;
		@(posedge core_clk);
		compare_flag_clear <= 2'h0;
		timer_count_write <= 1'h0;
		timer_tick <= 1'h1;
		@(posedge core_clk);
		timer_tick <= 1'h0;
		cyc(2);
		chk("blocked", compare_flag, 2'h0);
		for (int i = 0; i < 2; i++) begin
			setup(i ? 4'hf : 4'h0, 16'h0000);
			force_compare_strobe <= 2'h3;
			@(posedge core_clk);
			force_compare_strobe <= 2'h0;
			#1;
			chk("force_event", compare_event, i ? 2'h0 : 2'h3);
			cyc(2);
			chk("force", compare_flag, 2'h0);
		end
		wr(3'h3, 8'h00);
		wr(3'h2, 8'h55);
		cyc(2);
		chk("buffered", top_value, 16'h1234);
		@(posedge core_clk);
		at_top <= 1'h1;
		tick(1);
		at_top <= 1'h0;
		cyc(2);
		chk("at_top_load", top_value, 16'h0055);
		setup(4'h0, 16'h5678);
		src.drive(1'h1, 1'h0);
		lat(n);
		chk("latency", 16'(n), 16'h0003);
		chk("cap_value", capture_value, 16'h5678);
		rd(3'h0, 8'h78, "cap_low");
		rd(3'h1, 8'h56, "cap_high");
		@(posedge core_clk);
		capture_filter_enable <= 1'h1;
		capture_edge_select <= 1'h0;
		clr();
		chk("w1c", capture_flag, 1'h0);
		src.drive(1'h0, 1'h0);
		src.drive(1'h1, 1'h0);
		cyc(12);
		chk("glitch", capture_flag, 1'h0);
		src.drive(1'h0, 1'h0);
		lat(m);
		chk("filtered", 16'(m), 16'(n + 4));
		@(posedge core_clk);
		comparator_capture_select <= 1'h1;
		capture_edge_select <= 1'h1;
		capture_filter_enable <= 1'h0;
		cyc(10);
		clr();
		src.drive(1'h0, 1'h1);
		lat(n);
		cyc(1);
		chk("comparator", capture_irq, 1'h1);
		@(posedge core_clk);
		capture_irq_ack <= 1'h1;
		@(posedge core_clk);
		capture_irq_ack <= 1'h0;
		cyc(1);
		chk("ack", capture_flag, 1'h0);
		chk("ack_irq", capture_irq, 1'h0);
		wr(3'h0, 8'hee);
		cyc(1);
		chk("cap_ro", capture_value, 16'h5678);
		setup(4'hc, 16'h5678);
		wr(3'h1, 8'h0a);
		wr(3'h0, 8'hbc);
		src.drive(1'h0, 1'h0);
		src.drive(1'h0, 1'h1);
		cyc(12);
		chk("cap_top", capture_value, 16'h0abc);
		chk("no_cap", capture_flag, 1'h0);
		chk("top_cap", top_value, 16'h0abc);
		chk("top_src", top_from_capture, 1'h1);
		results();
	end
endmodule : tb_timer_capture_compare_units
`default_nettype wire
